// ==== design/door_diag_pkg.sv ====
package door_diag_pkg;
  // Clock rate and timing figures in their own units
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WARN_TIME_MIN = 30;
  localparam int unsigned PAUSE_TIME_MIN = 10;
  localparam int unsigned BLINK_HZ = 1;
  localparam int unsigned PULSE_ON_MS = 200;
  localparam int unsigned PULSE_OFF_MS = 200;
  localparam int unsigned GROUP_GAP_MS = 1500;
  // Derived cycle counts
  localparam longint unsigned WARN_CYCLES = 64'(WARN_TIME_MIN) * 60 * CLK_HZ;
  localparam longint unsigned PAUSE_CYCLES = 64'(PAUSE_TIME_MIN) * 60 * CLK_HZ;
  localparam longint unsigned HALF_BLINK_CYCLES = 64'(CLK_HZ) / (2 * BLINK_HZ);
  localparam longint unsigned PULSE_ON_CYCLES = 64'(PULSE_ON_MS) * (CLK_HZ / 1000);
  localparam longint unsigned PULSE_OFF_CYCLES = 64'(PULSE_OFF_MS) * (CLK_HZ / 1000);
  localparam longint unsigned GROUP_GAP_CYCLES = 64'(GROUP_GAP_MS) * (CLK_HZ / 1000);
  // Error cause codes, value is the red pulse count
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_OUT_A = 3'h1;
  localparam logic [2:0] CODE_OUT_B = 3'h2;
  localparam logic [2:0] CODE_CROSS = 3'h3;
  localparam logic [2:0] CODE_TEMP = 3'h4;
  localparam logic [2:0] CODE_ACTUATOR = 3'h5;
  typedef enum {ST_IDLE, ST_ACTUATED, ST_WARN, ST_ERROR, ST_INTERNAL, ST_TEACH, ST_PAUSE} mode_t;
endpackage

// ==== design/pulse_code_gen.sv ====
`timescale 1ns/100ps
// Red pulse-group generator: emits count pulses, then a long dark gap, repeating
module pulse_code_gen
  import door_diag_pkg::*;
#(
  parameter int unsigned ON_CYCLES = 32'(PULSE_ON_CYCLES),
  parameter int unsigned OFF_CYCLES = 32'(PULSE_OFF_CYCLES),
  parameter int unsigned GAP_CYCLES = 32'(GROUP_GAP_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] count,
  output logic led
);
  if (ON_CYCLES < 1 || OFF_CYCLES < 1 || GAP_CYCLES <= OFF_CYCLES) begin : g_bad_timing
    $error("pulse_code_gen: bad timing");
  end
  logic [31:0] tmr_q;
  logic [2:0] idx_q;
  logic phase_on_q;
  logic in_gap_q;

  // Count on, off and gap phases; a zero count keeps the LED dark
  always_ff @(posedge clk) begin
    if (rst || count == CODE_NONE) begin
      tmr_q <= 32'h0;
      idx_q <= 3'h0;
      phase_on_q <= 1'b0;
      in_gap_q <= 1'b1;
    end else if (tmr_q != 32'h0) begin
      tmr_q <= tmr_q - 32'h1;
    end else if (in_gap_q || !phase_on_q) begin
      if (in_gap_q || idx_q < count) begin
        phase_on_q <= 1'b1;
        in_gap_q <= 1'b0;
        idx_q <= in_gap_q ? 3'h1 : idx_q + 3'h1;
        tmr_q <= ON_CYCLES - 1;
      end else begin
        in_gap_q <= 1'b1;
        tmr_q <= GAP_CYCLES - 1;
      end
    end else begin
      phase_on_q <= 1'b0;
      tmr_q <= OFF_CYCLES - 1;
    end
  end

  // Registered LED drive
  always_ff @(posedge clk) begin
    if (rst) begin
      led <= 1'b0;
    end else begin
      led <= (count != CODE_NONE) && phase_on_q && !in_gap_q;
    end
  end
endmodule // pulse_code_gen

// ==== design/door_switch_diagnostic_fsm.sv ====
`timescale 1ns/100ps
module door_switch_diagnostic_fsm
  import door_diag_pkg::*;
#(
  parameter longint unsigned WARN_LIMIT = WARN_CYCLES,
  parameter longint unsigned PAUSE_LIMIT = PAUSE_CYCLES,
  parameter int unsigned HALF_BLINK = 32'(HALF_BLINK_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic actuator_present,
  input wire logic actuator_limit,
  input wire logic cascade_input_a,
  input wire logic cascade_input_b,
  input wire logic teach_active,
  input wire logic teach_done,
  input wire logic internal_fault,
  input wire logic warn_temp,
  input wire logic warn_cross,
  input wire logic fault_out_a,
  input wire logic fault_out_b,
  input wire logic fault_actuator,
  output logic safety_output_a,
  output logic safety_output_b,
  output logic aux_output,
  output logic led_green,
  output logic led_red,
  output logic led_yellow,
  output logic [2:0] error_code
);
  if (WARN_LIMIT < 2 || PAUSE_LIMIT < 2 || HALF_BLINK < 1) begin : g_bad_timing
    $error("door_switch_diagnostic_fsm: bad timing");
  end

  // Two-stage synchronisers for every pin input
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw = {actuator_present, actuator_limit, cascade_input_a, cascade_input_b, teach_active, teach_done,
                internal_fault, warn_temp, warn_cross, fault_out_a, fault_out_b, fault_actuator};
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic act, lim, cas_a, cas_b, teach, tdone, ifault, wtemp, wcross, fa, fb, fact;
  assign {act, lim, cas_a, cas_b, teach, tdone, ifault, wtemp, wcross, fa, fb, fact} = s2_q;

  logic warn_any;
  logic err_any;
  logic cascade_fault;
  logic [2:0] cause;
  assign warn_any = wtemp | wcross;
  assign err_any = fa | fb | fact;
  assign cascade_fault = !cas_a || !cas_b;
  // Lowest code wins when several causes stand together
  always_comb begin
    cause = CODE_NONE;
    if (fact) cause = CODE_ACTUATOR;
    if (wtemp) cause = CODE_TEMP;
    if (wcross) cause = CODE_CROSS;
    if (fb) cause = CODE_OUT_B;
    if (fa) cause = CODE_OUT_A;
  end

  // 1 Hz blink base shared by the green, yellow and aux flashing; red pulses come from u_pulse
  logic [31:0] blink_cnt_q;
  logic blink_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      blink_cnt_q <= 32'h0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q >= HALF_BLINK - 1) begin
      blink_cnt_q <= 32'h0;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  mode_t state_q;
  logic [63:0] warn_cnt_q;
  logic warn_expired;
  logic [63:0] pause_cnt_q;
  logic [2:0] latched_code_q;
  assign warn_expired = warn_cnt_q >= WARN_LIMIT - 1;

  // Main mode sequencing; an internal fault takes priority over everything except reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (ifault) begin
      state_q <= ST_INTERNAL;
    end else begin
      case (state_q)
        ST_IDLE, ST_ACTUATED: begin
          if (teach) state_q <= ST_TEACH;
          else if (err_any || (warn_any && !act)) state_q <= ST_ERROR;
          else if (warn_any) state_q <= ST_WARN;
          else state_q <= act ? ST_ACTUATED : ST_IDLE;
        end
        ST_WARN: begin
          if (err_any || !act || warn_expired) state_q <= ST_ERROR;
          else if (!warn_any) state_q <= ST_ACTUATED;
        end
        ST_ERROR, ST_INTERNAL: begin
          // clear needs cause gone and door open
          if (!err_any && !warn_any && !act) state_q <= ST_IDLE;
        end
        ST_TEACH: begin
          if (tdone) state_q <= ST_PAUSE;
        end
        ST_PAUSE: begin
          if (pause_cnt_q >= PAUSE_LIMIT - 1) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Warning timer counts only while in warning mode
  always_ff @(posedge clk) begin
    if (rst || state_q != ST_WARN) warn_cnt_q <= 64'h0;
    else if (!warn_expired) warn_cnt_q <= warn_cnt_q + 64'h1;
  end

  // Pause timer restarts on each entry; a reset clears it and sends the mode to idle, not back to pause
  always_ff @(posedge clk) begin
    if (rst || state_q != ST_PAUSE) pause_cnt_q <= 64'h0;
    else pause_cnt_q <= pause_cnt_q + 64'h1;
  end

  // Cause is latched on error entry so a vanished cause still shows until cleared
  always_ff @(posedge clk) begin
    if (rst) latched_code_q <= CODE_NONE;
    else if (state_q != ST_ERROR) latched_code_q <= cause;
    else if (cause != CODE_NONE) latched_code_q <= cause;
  end

  logic [2:0] pulse_count;
  logic red_pulse;
  assign pulse_count = (state_q == ST_ERROR || state_q == ST_WARN) ?
                       ((latched_code_q == CODE_NONE) ? CODE_ACTUATOR : latched_code_q) : CODE_NONE;
  pulse_code_gen u_pulse (
    .clk(clk),
    .rst(rst),
    .count(pulse_count),
    .led(red_pulse)
  );

  // Output decode per mode; registered so pins are glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
      aux_output <= 1'b0;
      led_green <= 1'b0;
      led_red <= 1'b0;
      led_yellow <= 1'b0;
      error_code <= CODE_NONE;
    end else begin
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
      aux_output <= 1'b0;
      led_green <= 1'b0;
      led_red <= 1'b0;
      led_yellow <= 1'b0;
      error_code <= pulse_count;
      case (state_q)
        ST_IDLE: begin
          if (cascade_fault) begin
            led_green <= blink_q;
          end else begin
            led_green <= 1'b1;
          end
        end
        ST_ACTUATED: begin
          if (cascade_fault) begin
            led_green <= blink_q;
            led_yellow <= act;
            aux_output <= act;
          end else if (lim) begin
            led_green <= 1'b1;
            led_yellow <= blink_q;
            aux_output <= blink_q;
            safety_output_a <= act;
            safety_output_b <= act;
          end else begin
            led_green <= 1'b1;
            led_yellow <= act;
            aux_output <= act;
            safety_output_a <= act;
            safety_output_b <= act;
          end
        end
        ST_WARN: begin
          led_red <= red_pulse;
          led_yellow <= 1'b1;
          safety_output_a <= act && !ifault;
          safety_output_b <= act && !ifault;
        end
        ST_ERROR: begin
          led_red <= red_pulse;
          led_yellow <= act;
        end
        ST_INTERNAL: begin
          led_red <= 1'b1;
        end
        ST_TEACH: begin
          led_red <= 1'b1;
          led_yellow <= blink_q;
        end
        ST_PAUSE: begin
          led_green <= blink_q;
        end
        default: begin
          led_red <= 1'b1;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_internal_off;
    ifault |-> ##2 !safety_output_a && !safety_output_b;
  endproperty
  a_internal_off: assert property (p_internal_off) else $error("outputs on after internal fault");
  property p_clear_door_open;
    $past(state_q) == ST_ERROR && state_q == ST_IDLE |-> !$past(act);
  endproperty
  a_clear_door_open: assert property (p_clear_door_open) else $error("error cleared with door closed");
  property p_warn_keeps;
    state_q == ST_WARN && act && !ifault |=> safety_output_a && safety_output_b && !aux_output;
  endproperty
  a_warn_keeps: assert property (p_warn_keeps) else $error("warning did not hold outputs");
  property p_warn_clear;
    state_q == ST_WARN && !warn_any && !err_any && act && !warn_expired && !ifault |=> state_q == ST_ACTUATED;
  endproperty
  a_warn_clear: assert property (p_warn_clear) else $error("warning not reset");
  property p_code;
    state_q == ST_ERROR |=> error_code != CODE_NONE;
  endproperty
  a_code: assert property (p_code) else $error("error without code");
  property p_teach_led;
    state_q == ST_TEACH && !ifault |=> led_red && !led_green && !safety_output_a && !aux_output;
  endproperty
  a_teach_led: assert property (p_teach_led) else $error("teach indication wrong");
  property p_pause;
    state_q == ST_PAUSE |=> !led_red && !led_yellow && !safety_output_b && !aux_output;
  endproperty
  a_pause: assert property (p_pause) else $error("pause outputs wrong");
  property p_cascade;
    state_q == ST_ACTUATED && cascade_fault |=> !safety_output_a && !safety_output_b;
  endproperty
  a_cascade: assert property (p_cascade) else $error("safety on with cascade fault");
  property p_leave;
    !act |=> !safety_output_a && !safety_output_b;
  endproperty
  a_leave: assert property (p_leave) else $error("safety on without actuator");
  c_actuated: cover property (state_q == ST_ACTUATED ##1 safety_output_a);
  c_warn_expire: cover property (state_q == ST_WARN ##1 state_q == ST_ERROR);
  c_pause: cover property (state_q == ST_TEACH ##1 state_q == ST_PAUSE);
endmodule // door_switch_diagnostic_fsm

// ==== sim/safety_plc_model.sv ====
`timescale 1ns/100ps
// Downstream controller input stage watching both safety channels
module safety_plc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic chan_a,
  input wire logic chan_b,
  output logic run_q,
  output logic split_q
);
  logic [1:0] gap_q;
  // Machine may run only while both channels are high
  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= chan_a & chan_b;
    end
  end
  // Channels may differ for a cycle or two at most, longer means a broken pair
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_q <= 2'h0;
      split_q <= 1'b0;
    end else begin
      gap_q <= (chan_a != chan_b) ? gap_q + 2'h1 : 2'h0;
      if (gap_q == 2'h3) begin
        split_q <= 1'b1;
      end
    end
  end
endmodule // safety_plc_model

// ==== sim/door_switch_diagnostic_fsm_tb.sv ====
`timescale 1ns/100ps
module door_switch_diagnostic_fsm_tb;
  import door_diag_pkg::*;
  localparam int WL = 200;
  localparam logic [11:0] ACT = 12'h001;
  localparam logic [11:0] LIM = 12'h002;
  localparam logic [11:0] CA = 12'h004;
  localparam logic [11:0] CB = 12'h008;
  localparam logic [11:0] CAS = 12'h00C;
  localparam logic [11:0] TA = 12'h010;
  localparam logic [11:0] TD = 12'h020;
  localparam logic [11:0] INT = 12'h040;
  localparam logic [11:0] WT = 12'h080;
  localparam logic [11:0] WC = 12'h100;
  localparam logic [11:0] CAUSE [5] = '{12'h200, 12'h400, WC, WT, 12'h800};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] pins = CAS;
  wire [5:0] outs;
  logic [5:0] seen1;
  logic [5:0] seen0;
  logic [2:0] error_code;
  logic plc_run;
  logic plc_split;
  int n_errors = 0;
  int total_checks = 0;
  // Free running 100 MHz clock
  always #5 clk = ~clk;
  // Output order in outs: safety a, safety b, aux, green, red, yellow
  door_switch_diagnostic_fsm #(.WARN_LIMIT(WL), .PAUSE_LIMIT(100), .HALF_BLINK(5)) uut (
    .clk(clk), .rst(rst), .actuator_present(pins[0]), .actuator_limit(pins[1]),
    .cascade_input_a(pins[2]), .cascade_input_b(pins[3]), .teach_active(pins[4]), .teach_done(pins[5]),
    .internal_fault(pins[6]), .warn_temp(pins[7]), .warn_cross(pins[8]), .fault_out_a(pins[9]),
    .fault_out_b(pins[10]), .fault_actuator(pins[11]), .safety_output_a(outs[5]), .safety_output_b(outs[4]),
    .aux_output(outs[3]), .led_green(outs[2]), .led_red(outs[1]), .led_yellow(outs[0]),
    .error_code(error_code));
  safety_plc_model plc (.clk(clk), .rst(rst), .chan_a(outs[5]), .chan_b(outs[4]), .run_q(plc_run),
    .split_q(plc_split));
  // Eight cycles cover the sync and register latency
  task automatic drive(input logic [11:0] v);
    @(posedge clk);
    pins <= v;
    repeat (8) @(posedge clk);
    // Step off the edge so outputs are read settled
    #1;
  endtask
  // Steady outputs show in one seen vector only, flashing ones in both
  task automatic watch(input int n);
    seen1 = 6'h00;
    seen0 = 6'h00;
    repeat (n) begin
      @(posedge clk);
      #1;
      seen1 = seen1 | outs;
      seen0 = seen0 | ~outs;
    end
  endtask
  task automatic chk_out(input string what, input logic [5:0] e1, input logic [5:0] e0, input logic [5:0] m);
    total_checks++;
    if ((((seen1 ^ e1) | (seen0 ^ e0)) & m) !== 6'h00) begin
      n_errors++;
      $display("[FAIL] %s expected %b/%b seen %b/%b", what, e1, e0, seen1, seen0);
    end
  endtask
  task automatic chk_code(input string what, input logic [2:0] e, input logic [2:0] got);
    total_checks++;
    if (got !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    pins <= CAS;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    drive(CAS);
    watch(20);
    chk_out("idle", 6'b000100, 6'b111011, 6'h3F);
  endtask
  task automatic t_actuated();
    drive(CAS | ACT);
    watch(20);
    chk_out("actuated", 6'b111101, 6'b000010, 6'h3F);
    chk_code("plc run", 3'h1, {2'h0, plc_run});
    drive(CAS | ACT | LIM);
    watch(30);
    chk_out("limit", 6'b111101, 6'b001011, 6'h3F);
    // Drop must land within five cycles plus sampling slack
    drive(CAS | ACT);
    @(posedge clk);
    pins <= CAS;
    repeat (5) @(posedge clk);
    #1;
    chk_code("safety after leave", 3'h0, {1'b0, outs[5:4]});
  endtask
  // Red pulses outlast any watch, so warn and error show the first pulse steadily on
  task automatic t_warn();
    drive(CAS | ACT | WT);
    watch(20);
    chk_out("warn", 6'b110011, 6'b001100, 6'h3F);
    drive(CAS | ACT);
    watch(20);
    chk_out("warn cleared", 6'b111101, 6'b000010, 6'h3F);
    chk_code("code after warn", 3'h0, error_code);
    drive(CAS | ACT | WC);
    repeat (WL - 30) @(posedge clk);
    watch(10);
    chk_out("warn before limit", 6'b110000, 6'b000000, 6'b110000);
    repeat (40) @(posedge clk);
    watch(10);
    chk_out("warn expired", 6'b000011, 6'b111100, 6'h3F);
    drive(CAS);
    // A warning with the door open goes straight to error
    drive(CAS | WT);
    chk_code("warn door open", 3'h4, error_code);
    drive(CAS);
  endtask
  task automatic t_codes();
    for (int i = 0; i < 5; i++) begin
      drive(CAS | ACT | CAUSE[i]);
      chk_code("cause code", 3'(i + 1), error_code);
      drive(CAS | ACT);
      chk_code("code held", (i < 2 || i == 4) ? 3'(i + 1) : 3'h0, error_code);
      drive(CAS);
      chk_code("code after open", 3'h0, error_code);
    end
  endtask
  task automatic t_internal();
    // Start actuated so the fault has live safety outputs to drop
    drive(CAS | ACT);
    drive(CAS | ACT | INT);
    watch(20);
    chk_out("internal", 6'b000010, 6'b111101, 6'h3F);
    drive(CAS);
    watch(20);
    chk_out("internal cleared", 6'b000100, 6'b111011, 6'h3F);
  endtask
  task automatic t_cascade();
    drive(CB | ACT);
    watch(30);
    chk_out("cascade closed", 6'b001101, 6'b110110, 6'h3F);
    drive(CA);
    watch(30);
    chk_out("cascade open", 6'b000100, 6'b111111, 6'h3F);
    drive(CAS);
  endtask
  // Pause runs its 100 cycle timer, then the present actuator is taken; a reset follows as after power loss
  task automatic t_teach();
    drive(CAS | ACT | TA);
    watch(30);
    chk_out("teach", 6'b000011, 6'b111101, 6'h3F);
    drive(CAS | ACT | TD);
    watch(30);
    chk_out("pause", 6'b000100, 6'b111111, 6'h3F);
    repeat (50) @(posedge clk);
    watch(10);
    chk_out("pause held", 6'b000100, 6'b111111, 6'h3F);
    repeat (10) @(posedge clk);
    watch(10);
    chk_out("pause over", 6'b111101, 6'b000010, 6'h3F);
    do_reset();
  endtask
  task automatic tally_and_finish();
    chk_code("channel split", 3'h0, {2'h0, plc_split});
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_actuated();
    t_warn();
    t_codes();
    t_internal();
    t_cascade();
    t_teach();
    tally_and_finish();
  end
endmodule // door_switch_diagnostic_fsm_tb
